// File: wcd_decoder.sv
// Watchdog command decoder with AHB-Lite register slave
// Functional notes
// - Each read-request one bit queues one readback, highest bit first; zero does nothing.
// - Main request bits 4..0: functional cfg, wd cfg one, op status one/zero, diag zero.
// - Watchdog request bits 3..0: wd status one/zero, heartbeat timer one/zero; 7..4 reserved.
// - Window service command bits 7..2 load the closed-window time field.
// - Closed-window code zero leaves both window settings unchanged.
// - Nonzero closed-window code gives code times 1.6 ms.
// - Window service bits 1..0 give open window of 3.2 ms times code plus one.
// - A full byte written to the response command is the functional answer.
// - Response-with-sync command takes the answer and resyncs the heartbeat.
// - Heartbeat period command loads the period and resyncs; zero changes nothing.
// - Nonzero heartbeat code gives code times 1.6 ms.
// - Software reset starts only on code 11.
// - Output-enable command clears on 01, sets on 10, else unchanged.
// - Lock command clears on 01, sets on 10, else unchanged.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps

module wcd_decoder #(
   parameter int unsigned TICK_CYCLES = wcd_pkg::STEP_CYCLES
) (
   input  wire logic                            clk_sys,
   input  wire logic                            rst,
   input  wire logic                            hsel,
   input  wire logic [31:0]                     haddr,
   input  wire logic [1:0]                      htrans,
   input  wire logic                            hwrite,
   input  wire logic [2:0]                      hsize,
   input  wire logic [31:0]                     hwdata,
   input  wire logic                            hready,
   output logic                                 hreadyout,
   output logic                                 hresp,
   output logic [31:0]                          hrdata,
   input  wire logic                            readback_ready,
   output logic                                 readback_valid,
   output logic [wcd_pkg::RB_ID_W-1:0]          readback_id,
   output logic [5:0]                           closed_window_time,
   output logic [1:0]                           open_window_time,
   output logic [wcd_pkg::CYC_W-1:0]            closed_window_cycles,
   output logic [wcd_pkg::CYC_W-1:0]            open_window_cycles,
   output logic [6:0]                           heartbeat_period,
   output logic [wcd_pkg::CYC_W-1:0]            heartbeat_cycles,
   output logic [7:0]                           functional_response_byte,
   output logic                                 functional_response_valid,
   output logic                                 heartbeat_sync,
   output logic                                 soft_reset_req,
   output logic                                 output_enable,
   output logic                                 config_lock
);
   import wcd_pkg::*;

   wcd_state_t s_r;
   wcd_state_t s_nxt;

   // Code times step, in clock cycles
   function automatic logic [CYC_W-1:0] ticks(input logic [6:0] code, input int unsigned mult);
      ticks = CYC_W'(32'(code) * mult * TICK_CYCLES);
   endfunction : ticks

   // Two-bit clear/set command on a level
   function automatic logic code_flag(input logic [1:0] code, input logic cur);
      case (code)
         CODE_CLEAR: code_flag = 1'b0;
         CODE_SET:   code_flag = 1'b1;
         default:    code_flag = cur;
      endcase
   endfunction : code_flag

   // Index of the highest pending readback request
   function automatic logic [RB_ID_W-1:0] top_bit(input logic [PEND_W-1:0] v);
      top_bit = '0;
      for (int i = 0; i < PEND_W; i++) begin
         if (v[i]) begin
            top_bit = RB_ID_W'(i);
         end
      end
   endfunction : top_bit

   // Next-state logic
   always_comb begin
      logic [PEND_W-1:0] new_req;
      logic [PEND_W-1:0] done;
      logic [31:0]       st;
      logic              addr_ok;
      logic [7:0]        wd;
      new_req = '0;
      done    = '0;
      st      = '0;
      wd      = hwdata[7:0];
      addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
      s_nxt   = s_r;
      s_nxt.hreadyout  = 1'b1;
      s_nxt.hresp      = HRESP_OKAY;
      s_nxt.resp_valid = 1'b0;
      s_nxt.hb_sync    = 1'b0;
      s_nxt.soft_rst   = 1'b0;

      // Data phase of a write: decode the command
      if (s_r.wr_pend) begin
         case (s_r.wr_idx)
            IDX_MAIN_RD: begin
               new_req[PEND_W-1 -: MAIN_RD_MSB+1] = wd[MAIN_RD_MSB:0];
            end
            IDX_WD_RD: begin
               new_req[WD_RD_MSB:0] = wd[WD_RD_MSB:0];
            end
            IDX_WIN_SVC: begin
               if (wd[CWT_MSB:CWT_LSB] != '0) begin
                  s_nxt.cwt    = wd[CWT_MSB:CWT_LSB];
                  s_nxt.owt    = wd[OWT_MSB:0];
                  s_nxt.cw_cyc = ticks(7'(wd[CWT_MSB:CWT_LSB]), 1);
                  s_nxt.ow_cyc = ticks(7'(wd[OWT_MSB:0]) + 7'h01, OPEN_MULT);
               end
            end
            IDX_RESP: begin
               s_nxt.resp_byte  = wd;
               s_nxt.resp_valid = 1'b1;
            end
            IDX_RESP_SYNC: begin
               s_nxt.resp_byte  = wd;
               s_nxt.resp_valid = 1'b1;
               s_nxt.hb_sync    = 1'b1;
            end
            IDX_HB_PERIOD: begin
               if (wd[HBP_MSB:0] != '0) begin
                  s_nxt.hbp     = wd[HBP_MSB:0];
                  s_nxt.hb_cyc  = ticks(wd[HBP_MSB:0], HB_MULT);
                  s_nxt.hb_sync = 1'b1;
               end
            end
            IDX_SOFT_RST: begin
               s_nxt.soft_rst = (wd[CODE2_MSB:0] == CODE_SOFT_RST);
            end
            IDX_OE: begin
               s_nxt.oe = code_flag(wd[CODE2_MSB:0], s_r.oe);
            end
            IDX_LOCK: begin
               s_nxt.lock = code_flag(wd[CODE2_MSB:0], s_r.lock);
            end
            default: begin
            end
         endcase
      end

      // Readback sequencer, one register at a time
      case (s_r.rb_state)
         RB_IDLE: begin
            if (s_r.pend != '0) begin
               s_nxt.rb_id    = top_bit(s_r.pend);
               s_nxt.rb_valid = 1'b1;
               s_nxt.rb_state = RB_SEND;
            end
         end
         RB_SEND: begin
            if (readback_ready) begin
               done[s_r.rb_id] = 1'b1;
               s_nxt.rb_valid  = 1'b0;
               s_nxt.rb_state  = RB_IDLE;
            end
         end
         default: begin
            s_nxt.rb_valid = 1'b0;
            s_nxt.rb_state = RB_IDLE;
         end
      endcase
      // New request wins over completion of the same bit
      s_nxt.pend = (s_r.pend & ~done) | new_req;

      // Address phase: capture write, prepare read data
      s_nxt.wr_pend = addr_ok && hwrite;
      s_nxt.wr_idx  = haddr[IDX_W+1:2];
      if (addr_ok && !hwrite) begin
         st[ST_PEND_LSB +: PEND_W] = s_r.pend;
         st[ST_CWT_LSB +: 6]       = s_r.cwt;
         st[ST_OWT_LSB +: 2]       = s_r.owt;
         st[ST_HBP_LSB +: 7]       = s_r.hbp;
         st[ST_OE_BIT]             = s_r.oe;
         st[ST_LOCK_BIT]           = s_r.lock;
         st[ST_BUSY_BIT]           = s_r.rb_valid;
         // Command registers are write-only and read as zero
         s_nxt.hrdata = (haddr[IDX_W+1:2] == IDX_STATUS) ? st : '0;
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_r.hreadyout  <= 1'b1;
         s_r.hresp      <= HRESP_OKAY;
         s_r.hrdata     <= '0;
         s_r.wr_pend    <= 1'b0;
         s_r.wr_idx     <= '0;
         s_r.rb_state   <= RB_IDLE;
         s_r.pend       <= '0;
         s_r.rb_valid   <= 1'b0;
         s_r.rb_id      <= '0;
         s_r.cwt        <= CWT_RST;
         s_r.owt        <= OWT_RST;
         s_r.cw_cyc     <= ticks(7'(CWT_RST), 1);
         s_r.ow_cyc     <= ticks(7'(OWT_RST) + 7'h01, OPEN_MULT);
         s_r.hbp        <= HBP_RST;
         s_r.hb_cyc     <= ticks(HBP_RST, HB_MULT);
         s_r.resp_byte  <= '0;
         s_r.resp_valid <= 1'b0;
         s_r.hb_sync    <= 1'b0;
         s_r.soft_rst   <= 1'b0;
         s_r.oe         <= OE_RST;
         s_r.lock       <= LOCK_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign hreadyout                 = s_r.hreadyout;
   assign hresp                     = s_r.hresp;
   assign hrdata                    = s_r.hrdata;
   assign readback_valid            = s_r.rb_valid;
   assign readback_id               = s_r.rb_id;
   assign closed_window_time        = s_r.cwt;
   assign open_window_time          = s_r.owt;
   assign closed_window_cycles      = s_r.cw_cyc;
   assign open_window_cycles        = s_r.ow_cyc;
   assign heartbeat_period          = s_r.hbp;
   assign heartbeat_cycles          = s_r.hb_cyc;
   assign functional_response_byte  = s_r.resp_byte;
   assign functional_response_valid = s_r.resp_valid;
   assign heartbeat_sync            = s_r.hb_sync;
   assign soft_reset_req            = s_r.soft_rst;
   assign output_enable             = s_r.oe;
   assign config_lock               = s_r.lock;

endmodule : wcd_decoder

// File: wcd_pkg.sv
// Constants and types for the watchdog command decoder
package wcd_pkg;

   // Clock and timing base
   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned CLOSED_STEP_NS = 1600000;  // 1.6 ms per closed-window code step
   localparam int unsigned OPEN_STEP_NS   = 3200000;  // 3.2 ms per open-window code step
   localparam int unsigned HB_STEP_NS     = 1600000;  // 1.6 ms per heartbeat code step
   localparam int unsigned STEP_CYCLES    = CLOSED_STEP_NS / CLK_PERIOD_NS;
   localparam int unsigned OPEN_MULT      = OPEN_STEP_NS / CLOSED_STEP_NS;
   localparam int unsigned HB_MULT        = HB_STEP_NS / CLOSED_STEP_NS;

   // Widths
   localparam int unsigned IDX_W   = 8;
   localparam int unsigned PEND_W  = 9;
   localparam int unsigned RB_ID_W = 4;
   localparam int unsigned CYC_W   = 24;

   // Register indexes; byte address is four times the index
   localparam logic [7:0] IDX_MAIN_RD   = 8'h0b;
   localparam logic [7:0] IDX_WD_RD     = 8'h0c;
   localparam logic [7:0] IDX_WIN_SVC   = 8'h15;
   localparam logic [7:0] IDX_RESP      = 8'h16;
   localparam logic [7:0] IDX_RESP_SYNC = 8'h17;
   localparam logic [7:0] IDX_HB_PERIOD = 8'h18;
   localparam logic [7:0] IDX_SOFT_RST  = 8'h19;
   localparam logic [7:0] IDX_OE        = 8'h1a;
   localparam logic [7:0] IDX_LOCK      = 8'h1b;
   localparam logic [7:0] IDX_STATUS    = 8'h1f;

   // Command field positions
   localparam int unsigned MAIN_RD_MSB = 4;
   localparam int unsigned WD_RD_MSB   = 3;
   localparam int unsigned CWT_MSB     = 7;
   localparam int unsigned CWT_LSB     = 2;
   localparam int unsigned OWT_MSB     = 1;
   localparam int unsigned HBP_MSB     = 6;
   localparam int unsigned CODE2_MSB   = 1;

   // Two-bit command codes
   localparam logic [1:0] CODE_SOFT_RST = 2'h3;
   localparam logic [1:0] CODE_CLEAR    = 2'h1;
   localparam logic [1:0] CODE_SET      = 2'h2;

   // Status register layout
   localparam int unsigned ST_PEND_LSB = 0;
   localparam int unsigned ST_CWT_LSB  = 12;
   localparam int unsigned ST_OWT_LSB  = 18;
   localparam int unsigned ST_HBP_LSB  = 20;
   localparam int unsigned ST_OE_BIT   = 28;
   localparam int unsigned ST_LOCK_BIT = 29;
   localparam int unsigned ST_BUSY_BIT = 31;

   // Reset values
   localparam logic [5:0] CWT_RST  = 6'h01;
   localparam logic [1:0] OWT_RST  = 2'h0;
   localparam logic [6:0] HBP_RST  = 7'h01;
   localparam logic       OE_RST   = 1'b0;
   localparam logic       LOCK_RST = 1'b0;

   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   // Readback sequencer states, one-hot
   typedef enum logic [1:0] {
      RB_IDLE = 2'b01,
      RB_SEND = 2'b10
   } wcd_rb_state_t;

   // All state of the decoder
   typedef struct packed {
      logic                 hreadyout;
      logic                 hresp;
      logic [31:0]          hrdata;
      logic                 wr_pend;
      logic [IDX_W-1:0]     wr_idx;
      wcd_rb_state_t        rb_state;
      logic [PEND_W-1:0]    pend;
      logic                 rb_valid;
      logic [RB_ID_W-1:0]   rb_id;
      logic [5:0]           cwt;
      logic [1:0]           owt;
      logic [CYC_W-1:0]     cw_cyc;
      logic [CYC_W-1:0]     ow_cyc;
      logic [6:0]           hbp;
      logic [CYC_W-1:0]     hb_cyc;
      logic [7:0]           resp_byte;
      logic                 resp_valid;
      logic                 hb_sync;
      logic                 soft_rst;
      logic                 oe;
      logic                 lock;
   } wcd_state_t;

endpackage : wcd_pkg

// File: wcd_decoder_asserts.sv
// Port-level checks for the watchdog command decoder
`timescale 1ns/1ps
module wcd_decoder_asserts
   import wcd_pkg::*;
(
   input wire logic         clk_sys,
   input wire logic         rst,
   input wire logic         hsel,
   input wire logic [31:0]  haddr,
   input wire logic [1:0]   htrans,
   input wire logic         hwrite,
   input wire logic [31:0]  hwdata,
   input wire logic         readback_ready,
   input wire logic         readback_valid,
   input wire logic [3:0]   readback_id,
   input wire logic [5:0]   closed_window_time,
   input wire logic [1:0]   open_window_time,
   input wire logic [6:0]   heartbeat_period,
   input wire logic [7:0]   functional_response_byte,
   input wire logic         functional_response_valid,
   input wire logic         heartbeat_sync,
   input wire logic         soft_reset_req,
   input wire logic         output_enable,
   input wire logic         config_lock
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Write address phase to one index, then its data phase
   sequence s_wr(logic [7:0] i);
      hsel && htrans == HTRANS_NONSEQ && hwrite && haddr[9:2] == i ##1 1'b1;
   endsequence
   // Address phase of a write elsewhere
   sequence s_other;
      hsel && htrans == HTRANS_NONSEQ && hwrite && haddr[9:2] != IDX_OE ##1 1'b1;
   endsequence
   property p_srst;
      s_wr(IDX_SOFT_RST) |=> soft_reset_req == ($past(hwdata[1:0]) == CODE_SOFT_RST);
   endproperty
   property p_oe;
      s_wr(IDX_OE) |=> output_enable == ($past(hwdata[1:0]) == CODE_SET ? 1'b1 :
         $past(hwdata[1:0]) == CODE_CLEAR ? 1'b0 : $past(output_enable));
   endproperty
   property p_lock;
      s_wr(IDX_LOCK) |=> config_lock == ($past(hwdata[1:0]) == CODE_SET ? 1'b1 :
         $past(hwdata[1:0]) == CODE_CLEAR ? 1'b0 : $past(config_lock));
   endproperty
   property p_win;
      s_wr(IDX_WIN_SVC) |=> {closed_window_time, open_window_time} ==
         ($past(hwdata[7:2]) != 6'h0 ? $past(hwdata[7:0]) : $past({closed_window_time,
         open_window_time}));
   endproperty
   property p_hb;
      s_wr(IDX_HB_PERIOD) |=> heartbeat_sync == ($past(hwdata[6:0]) != 7'h0) &&
         heartbeat_period == (heartbeat_sync ? $past(hwdata[6:0]) : $past(heartbeat_period));
   endproperty
   property p_resp;
      s_wr(IDX_RESP) |=> functional_response_valid && !heartbeat_sync &&
         functional_response_byte == $past(hwdata[7:0]);
   endproperty
   property p_rsync;
      s_wr(IDX_RESP_SYNC) |=> functional_response_valid && heartbeat_sync &&
         functional_response_byte == $past(hwdata[7:0]);
   endproperty
   property p_rbhold;
      readback_valid && !readback_ready |=> readback_valid && $stable(readback_id);
   endproperty
   property p_rbdrop;
      readback_valid && readback_ready |=> !readback_valid;
   endproperty
   property p_oeonly;
      s_other |=> $stable(output_enable);
   endproperty
   a_srst: assert property (p_srst) else $error("soft reset pulse wrong");
   a_oe: assert property (p_oe) else $error("output enable wrong");
   a_lock: assert property (p_lock) else $error("lock wrong");
   a_win: assert property (p_win) else $error("window codes wrong");
   a_hb: assert property (p_hb) else $error("heartbeat wrong");
   a_resp: assert property (p_resp) else $error("response wrong");
   a_rsync: assert property (p_rsync) else $error("response sync wrong");
   a_rbhold: assert property (p_rbhold) else $error("readback not held");
   a_rbdrop: assert property (p_rbdrop) else $error("readback not dropped");
   a_oeonly: assert property (p_oeonly) else $error("output enable moved");
endmodule : wcd_decoder_asserts

bind wcd_decoder wcd_decoder_asserts u_chk (.clk_sys, .rst, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .readback_ready, .readback_valid, .readback_id, .closed_window_time,
   .open_window_time, .heartbeat_period, .functional_response_byte,
   .functional_response_valid, .heartbeat_sync, .soft_reset_req, .output_enable,
   .config_lock);

// File: wcd_host.sv
// Host model: AHB-Lite master and readback consumer
`timescale 1ns/1ps
module wcd_host (
   input  wire logic        clk_sys,
   input  wire logic        hreadyout,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   output logic             readback_ready
);
   import wcd_pkg::*;
   int seed = 32'hf37c;
   function automatic logic [31:0] rnd();
      return $random(seed);
   endfunction : rnd
   // Idle bus at time zero
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      readback_ready = 1'b0;
   end
   // Random stalls while taking readback items
   always @(posedge clk_sys) readback_ready <= (rnd() % 3) == 0;
   // One whole-word transfer; released lines show inverted data
   task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d,
                       output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {22'h0, i, 2'h0};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      haddr <= ~haddr;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      q = hrdata;
      hwdata <= ~d;
   endtask : xfer
endmodule : wcd_host

// File: watchdog_command_decoder_bench.sv
// Self-checking bench for the watchdog command decoder
`timescale 1ns/1ps
module watchdog_command_decoder_bench;
   import wcd_pkg::*;
   localparam int TK = 4;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        hsel, hwrite, hreadyout, hresp, readback_ready, readback_valid;
   logic        functional_response_valid, heartbeat_sync, soft_reset_req;
   logic        output_enable, config_lock;
   logic [1:0]  htrans, open_window_time;
   logic [2:0]  hsize;
   logic [3:0]  readback_id;
   logic [5:0]  closed_window_time;
   logic [6:0]  heartbeat_period;
   logic [7:0]  functional_response_byte;
   logic [23:0] closed_window_cycles, open_window_cycles, heartbeat_cycles;
   logic [31:0] haddr, hwdata, hrdata, r, d, e;
   int          miscompares, comparisons, cyc, k, e_oe, e_lk, e_ow, e_cw = 1, e_hb = 1;
   int          q[$];

   always #10 clk_sys = ~clk_sys;

   wcd_decoder #(.TICK_CYCLES(TK)) dut (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .readback_ready,
      .readback_valid, .readback_id, .closed_window_time, .open_window_time,
      .closed_window_cycles, .open_window_cycles, .heartbeat_period, .heartbeat_cycles,
      .functional_response_byte, .functional_response_valid, .heartbeat_sync,
      .soft_reset_req, .output_enable, .config_lock);
   wcd_host host (.clk_sys, .hreadyout, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .readback_ready);

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   // Bus access from the next edge, outputs settled on return
   task automatic xf(input logic w, input logic [7:0] i, input logic [31:0] v);
      @(posedge clk_sys);
      host.xfer(w, i, v, r);
      #1;
   endtask : xf
   task automatic chk_all();
      chk("cwt", closed_window_time, e_cw);
      chk("owt", open_window_time, e_ow);
      chk("cwc", closed_window_cycles, e_cw * TK);
      chk("owc", open_window_cycles, (e_ow + 1) * 2 * TK);
      chk("hbp", heartbeat_period, e_hb);
      chk("hbc", heartbeat_cycles, e_hb * TK);
      chk("oe", output_enable, e_oe);
      chk("lock", config_lock, e_lk);
      chk("bus", {hreadyout, hresp}, {1'b1, HRESP_OKAY});
      chk("pulse", {functional_response_valid, soft_reset_req}, 2'h0);
   endtask : chk_all
   task automatic close_out();
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   // Each accepted readback must be the oldest expected id
   always @(posedge clk_sys) begin
      if (readback_valid && readback_ready)
         chk("rbid", readback_id, q.size() > 0 ? q.pop_front() : 99);
   end
   // Hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc > 5000) begin
         miscompares++;
         close_out();
      end
   end

   // Main sequence
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk_all();
      // Codes set, none, none, clear, set: a clear must undo an earlier set
      for (k = 0; k < 5; k++) begin
         d = host.rnd();
         d[1:0] = k[1:0] ^ 2'h2;
         xf(1'b1, IDX_OE, d);
         xf(1'b1, IDX_LOCK, d);
         if (d[1:0] == CODE_CLEAR || d[1:0] == CODE_SET) e_oe = d[1];
         if (d[1:0] == CODE_CLEAR || d[1:0] == CODE_SET) e_lk = d[1];
         chk_all();
         xf(1'b1, IDX_SOFT_RST, d);
         chk("srst", soft_reset_req, d[1:0] == CODE_SOFT_RST);
      end
      for (k = 0; k < 6; k++) begin
         d = host.rnd();
         e = host.rnd();
         if (k == 0) d[7:0] = 8'h03;
         if (k == 1) d[7:0] = 8'hff;
         if (k == 0) e[6:0] = 7'h00;
         if (k == 1) e[6:0] = 7'h7f;
         xf(1'b1, IDX_WIN_SVC, d);
         if (d[7:2] != 6'h0) e_cw = d[7:2];
         if (d[7:2] != 6'h0) e_ow = d[1:0];
         xf(1'b1, IDX_HB_PERIOD, e);
         if (e[6:0] != 7'h0) e_hb = e[6:0];
         chk("hbs", heartbeat_sync, e[6:0] != 7'h0);
         chk_all();
         xf(1'b1, IDX_RESP + k % 2, d);
         chk("resp", functional_response_byte, d[7:0]);
         chk("rvld", functional_response_valid, 1'b1);
         chk("rsync", heartbeat_sync, k % 2);
      end
      xf(1'b1, IDX_MAIN_RD, 32'h0);
      q = {8, 7, 6, 5, 4, 3, 2, 1, 0};
      xf(1'b1, IDX_MAIN_RD, host.rnd() | 32'h1f);
      xf(1'b1, IDX_WD_RD, host.rnd() | 32'hf);
      for (k = 0; k < 3000 && q.size() > 0; k++) @(posedge clk_sys);
      chk("rbleft", q.size(), 0);
      xf(1'b0, 8'h30, 32'h0);
      chk("unmap", r, 32'h0);
      xf(1'b0, IDX_OE, 32'h0);
      chk("cmdrd", r, 32'h0);
      xf(1'b0, IDX_STATUS, 32'h0);
      chk("stat", r, {2'b0, e_lk[0], e_oe[0], 1'b0, e_hb[6:0], e_ow[1:0], e_cw[5:0],
          12'h0});
      close_out();
   end
endmodule : watchdog_command_decoder_bench
